// ===== hw/rtctl_core.sv
// real-time clock counters, read snapshot latch, alarm and interrupts
// assumes a processor on cs_n/rd_n/wr_n strobes with 5-bit address
// Operation
// - reading hundredths copies the seven other counters into the snapshot latch
// - hundredths value is returned live and never latched
// - the seven counters read from the latch until hundredths is read again
// - alarm storage reads return stored contents directly
// - status records which counters incremented since the last status read
// - increment status bits set regardless of mask settings
// - each status read clears the register right after returning it
// - status bit 7 set when an interrupt was raised since last read
// - alarm interrupt also sets status bit 0
// - interrupt output stays on until status is read
// - periodic interrupt needs enable bit 4 and a mask bit 1 to 6
// - periodic interrupt fires on each increment of an enabled counter
// - alarm interrupt needs enable bit 4 and mask bit 0
// - an exact alarm match with enable bit 4 and mask bit 0 set sets status bits 0 and 7 and drives output
// - masked alarm fields other than hundredths match every value
// - masked hundredths alarm field acts as zero
// - mask value 08 hex selects the one-second periodic interrupt
module rtctl_core
    import rtctl_pkg::*;
#(
    parameter int unsigned CLOCK_HZ = RTCTL_CLOCK_HZ,
    parameter int unsigned TICK_DIV = CLOCK_HZ / RTCTL_TICK_HZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // processor bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // open-drain interrupt pin
    input wire logic irq_in,
    output logic irq_out,
    output logic irq_oe_n
);
    rtctl_bus_t bus_pin;
    rtctl_bus_t s_bus;
    logic rd_act, wr_act, rd_prev_reg, wr_prev_reg;
    logic rd_start, rd_end, wr_start;
    logic [4:0] rd_addr_reg;
    logic [31:0] div_reg;
    logic tick_raw, tick_pend_reg, apply;
    logic [7:0] cmd_reg, mask_reg, status_reg, set_vec;
    logic [7:0] data_reg;
    rtctl_time_t time_reg, time_next, latch_reg, alarm_reg;
    logic [6:1] incr;
    logic [7:0] fld_match;
    logic alarm_hit, alarm_fire, periodic_fire, irq_event, irq_reg;
    logic status_clr, snap;

    // ==========================================================
    // pin synchronisation and strobe edges
    assign bus_pin = '{cs_n, rd_n, wr_n, addr, data_in};

    rtctl_sync #(.WIDTH(16), .RST_VAL(RTCTL_BUS_RST)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin_in(bus_pin),
        .sync_out(s_bus)
    );

    assign rd_act = !s_bus.cs_n && !s_bus.rd_n;
    assign wr_act = !s_bus.cs_n && !s_bus.wr_n;
    assign rd_start = rd_act && !rd_prev_reg;
    assign rd_end = !rd_act && rd_prev_reg;
    assign wr_start = wr_act && !wr_prev_reg;
    assign snap = rd_start && (s_bus.addr == RTCTL_OFS_HUND);
    assign status_clr = rd_end && (rd_addr_reg == RTCTL_OFS_STATUS);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            rd_addr_reg <= 5'h00;
        end else begin
            rd_prev_reg <= rd_act;
            wr_prev_reg <= wr_act;
            if (rd_start) begin
                rd_addr_reg <= s_bus.addr;
            end
        end
    end

    // ==========================================================
    // 100 Hz tick; held back during a read or a counter write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 32'h0000_0000;
        end else if (div_reg >= TICK_DIV - 1) begin
            div_reg <= 32'h0000_0000;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
        end
    end

    assign tick_raw = cmd_reg[RTCTL_CMD_RUN] &&
                      (cmd_reg[RTCTL_CMD_TEST] || div_reg >= TICK_DIV - 1);
    assign apply = tick_pend_reg && !rd_act && !(wr_start && s_bus.addr < RTCTL_OFS_ALARM);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_pend_reg <= 1'b0;
        end else if (tick_raw) begin
            tick_pend_reg <= 1'b1;
        end else if (apply) begin
            tick_pend_reg <= 1'b0;
        end
    end

    // ==========================================================
    // counter step and increment flags
    function automatic logic [7:0] days_in(input logic [7:0] month, input logic [7:0] year);
        case (month)
            8'h02: days_in = (year[1:0] == 2'b00) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: days_in = 8'h1e;
            default: days_in = 8'h1f;
        endcase
    endfunction

    always_comb begin
        time_next = time_reg;
        incr = '0;
        incr[RTCTL_ST_HUND] = 1'b1;
        incr[RTCTL_ST_TENTH] = ((time_reg.hund % 8'h0a) == 8'h09);
        time_next.hund = (time_reg.hund == RTCTL_HUND_MAX) ? 8'h00 : time_reg.hund + 8'h01;
        if (time_reg.hund == RTCTL_HUND_MAX) begin
            incr[RTCTL_ST_SEC] = 1'b1;
            time_next.sec = (time_reg.sec == RTCTL_SEC_MAX) ? 8'h00 : time_reg.sec + 8'h01;
            if (time_reg.sec == RTCTL_SEC_MAX) begin
                incr[RTCTL_ST_MIN] = 1'b1;
                time_next.min = (time_reg.min == RTCTL_SEC_MAX) ? 8'h00 : time_reg.min + 8'h01;
                if (time_reg.min == RTCTL_SEC_MAX) begin
                    incr[RTCTL_ST_HOUR] = 1'b1;
                    time_next.hour = (time_reg.hour == RTCTL_HOUR_MAX) ? 8'h00 :
                                     time_reg.hour + 8'h01;
                    if (time_reg.hour == RTCTL_HOUR_MAX) begin
                        incr[RTCTL_ST_DAY] = 1'b1;
                        time_next.day = (time_reg.day == RTCTL_DAY_MAX) ? 8'h00 :
                                        time_reg.day + 8'h01;
                        time_next.date = time_reg.date + 8'h01;
                        if (time_reg.date >= days_in(time_reg.month, time_reg.year)) begin
                            time_next.date = 8'h01;
                            time_next.month = time_reg.month + 8'h01;
                            if (time_reg.month >= RTCTL_MONTH_MAX) begin
                                time_next.month = 8'h01;
                                time_next.year = (time_reg.year == RTCTL_YEAR_MAX) ? 8'h00 :
                                                 time_reg.year + 8'h01;
                            end
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // time counters and alarm storage
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            time_reg <= RTCTL_TIME_RST;
        end else if (wr_start && s_bus.addr < RTCTL_OFS_ALARM) begin
            time_reg[{s_bus.addr[2:0], 3'b000} +: 8] <= s_bus.data;
        end else if (apply) begin
            time_reg <= time_next;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alarm_reg <= {8{RTCTL_ALARM_RST}};
        end else if (wr_start && s_bus.addr[4:3] == 2'b01) begin
            alarm_reg[{s_bus.addr[2:0], 3'b000} +: 8] <= s_bus.data;
        end
    end

    // ==========================================================
    // snapshot latch of the seven counters other than hundredths
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latch_reg <= RTCTL_TIME_RST;
        end else if (snap) begin
            latch_reg <= time_reg;
        end
    end

    // ==========================================================
    // command and mask registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmd_reg <= RTCTL_CMD_RST;
            mask_reg <= RTCTL_MASK_RST;
        end else if (wr_start) begin
            if (s_bus.addr == RTCTL_OFS_COMMAND) begin
                cmd_reg <= s_bus.data;
            end
            if (s_bus.addr == RTCTL_OFS_STATUS) begin
                mask_reg <= s_bus.data;
            end
        end
    end

    // ==========================================================
    // alarm compare on the value being loaded by the tick
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_cmp
            logic [7:0] a_b, t_b;
            assign a_b = alarm_reg[8*k +: 8];
            assign t_b = time_next[8*k +: 8];
            if (k == 0) begin : g_hund
                assign fld_match[k] = a_b[RTCTL_ALM_MASK] ? (t_b == 8'h00) :
                                      (a_b[6:0] == t_b[6:0]);
            end else begin : g_other
                assign fld_match[k] = a_b[RTCTL_ALM_MASK] || (a_b[6:0] == t_b[6:0]);
            end
        end
    endgenerate

    assign alarm_hit = apply && (&fld_match);
    assign alarm_fire = alarm_hit && cmd_reg[RTCTL_CMD_IE] && mask_reg[RTCTL_ST_ALARM];
    // mask bit 3 pairs with the seconds increment
    assign periodic_fire = apply && cmd_reg[RTCTL_CMD_IE] &&
                           (|(mask_reg[6:1] & incr));
    assign irq_event = periodic_fire || alarm_fire;

    // ==========================================================
    // status register: new events win over the read clear
    always_comb begin
        set_vec = 8'h00;
        if (apply) begin
            set_vec[6:1] = incr;
        end
        set_vec[RTCTL_ST_ALARM] = alarm_fire;
        set_vec[RTCTL_ST_IRQ] = irq_event;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= RTCTL_STATUS_RST;
        end else begin
            status_reg <= set_vec | (status_clr ? 8'h00 : status_reg);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else if (irq_event) begin
            irq_reg <= 1'b1;
        end else if (status_clr) begin
            irq_reg <= 1'b0;
        end
    end

    assign irq_out = 1'b0;
    assign irq_oe_n = !irq_reg;

    // ==========================================================
    // read data, captured at the start of the read strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= 8'h00;
        end else if (rd_start) begin
            if (s_bus.addr == RTCTL_OFS_HUND) begin
                data_reg <= time_reg.hund;
            end else if (s_bus.addr < RTCTL_OFS_ALARM) begin
                data_reg <= latch_reg[{s_bus.addr[2:0], 3'b000} +: 8];
            end else if (s_bus.addr[4:3] == 2'b01) begin
                data_reg <= alarm_reg[{s_bus.addr[2:0], 3'b000} +: 8];
            end else if (s_bus.addr == RTCTL_OFS_STATUS) begin
                data_reg <= status_reg;
            end else if (s_bus.addr == RTCTL_OFS_COMMAND) begin
                data_reg <= cmd_reg;
            end else begin
                data_reg <= 8'h00;
            end
        end
    end

    assign data_out = data_reg;
    assign data_oe_n = !(rd_act && rd_prev_reg);

    // ==========================================================
    // checks
    sequence s_status_read;
        status_clr && !irq_event;
    endsequence

    sequence s_irq_hold;
        irq_reg && !status_clr;
    endsequence

    property p_snap;
        @(posedge clock) disable iff (!reset_n) snap |=> latch_reg == $past(time_reg);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not taken");

    property p_live;
        @(posedge clock) disable iff (!reset_n)
            snap && !apply |=> data_out == time_reg.hund;
    endproperty
    a_live: assert property (p_live) else $error("hundredths not live");

    property p_hold;
        @(posedge clock) disable iff (!reset_n) !snap |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed");

    property p_alarm_rd;
        @(posedge clock) disable iff (!reset_n)
            rd_start && s_bus.addr == 5'h09 |=> data_out == alarm_reg.hour;
    endproperty
    a_alarm_rd: assert property (p_alarm_rd) else $error("alarm read wrong");

    property p_sec_flag;
        @(posedge clock) disable iff (!reset_n)
            apply && time_reg.hund == RTCTL_HUND_MAX |=> status_reg[RTCTL_ST_SEC];
    endproperty
    a_sec_flag: assert property (p_sec_flag) else $error("seconds flag missing");

    property p_clear;
        @(posedge clock) disable iff (!reset_n) status_clr |=> status_reg == $past(set_vec);
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_irq_bit;
        @(posedge clock) disable iff (!reset_n) irq_event |=> status_reg[7] && !irq_oe_n;
    endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("irq bit missing");

    property p_irq_release;
        @(posedge clock) disable iff (!reset_n) s_status_read |=> irq_oe_n;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq not released");

    property p_irq_keep;
        @(posedge clock) disable iff (!reset_n) s_irq_hold |=> !irq_oe_n;
    endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("irq dropped early");

    property p_periodic;
        @(posedge clock) disable iff (!reset_n)
            apply && cmd_reg[RTCTL_CMD_IE] && mask_reg[RTCTL_ST_HUND] |=> !irq_oe_n;
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic irq missing");

    property p_alarm;
        @(posedge clock) disable iff (!reset_n)
            alarm_fire |=> status_reg[0] && status_reg[7] && !irq_oe_n;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm irq missing");

    property p_hund_zero;
        @(posedge clock) disable iff (!reset_n)
            alarm_hit && alarm_reg.hund[RTCTL_ALM_MASK] |=> time_reg.hund == 8'h00;
    endproperty
    a_hund_zero: assert property (p_hund_zero) else $error("masked hundredths not zero");

    property p_once;
        @(posedge clock) disable iff (!reset_n) alarm_hit |-> apply ##1 !alarm_hit;
    endproperty
    a_once: assert property (p_once) else $error("alarm outside tick");
endmodule

// ===== common/rtctl_pkg.sv
// package for the real-time clock latch and interrupt block
// assumes a single 50 MHz clock and an 8-bit strobed processor bus
package rtctl_pkg;

    // ==========================================================
    // timing
    localparam int unsigned RTCTL_CLOCK_HZ = 50_000_000;
    localparam int unsigned RTCTL_TICK_HZ = 100;

    // ==========================================================
    // register offsets
    localparam logic [4:0] RTCTL_OFS_HUND = 5'h00;
    localparam logic [4:0] RTCTL_OFS_ALARM = 5'h08;
    localparam logic [4:0] RTCTL_OFS_STATUS = 5'h10;
    localparam logic [4:0] RTCTL_OFS_COMMAND = 5'h11;

    // ==========================================================
    // status and mask bit positions
    localparam int RTCTL_ST_ALARM = 0;
    localparam int RTCTL_ST_HUND = 1;
    localparam int RTCTL_ST_TENTH = 2;
    localparam int RTCTL_ST_SEC = 3;
    localparam int RTCTL_ST_MIN = 4;
    localparam int RTCTL_ST_HOUR = 5;
    localparam int RTCTL_ST_DAY = 6;
    localparam int RTCTL_ST_IRQ = 7;

    // command bit positions
    localparam int RTCTL_CMD_RUN = 3;
    localparam int RTCTL_CMD_IE = 4;
    localparam int RTCTL_CMD_TEST = 5;

    // alarm byte bit that leaves a field other than hundredths out of the compare
    localparam int RTCTL_ALM_MASK = 7;

    // ==========================================================
    // reset values
    localparam logic [7:0] RTCTL_CMD_RST = 8'h00;
    localparam logic [7:0] RTCTL_MASK_RST = 8'h00;
    localparam logic [7:0] RTCTL_STATUS_RST = 8'h00;
    localparam logic [7:0] RTCTL_ALARM_RST = 8'h00;
    localparam logic [15:0] RTCTL_BUS_RST = 16'he000;

    // ==========================================================
    // counter limits
    localparam logic [7:0] RTCTL_HUND_MAX = 8'h63;
    localparam logic [7:0] RTCTL_SEC_MAX = 8'h3b;
    localparam logic [7:0] RTCTL_HOUR_MAX = 8'h17;
    localparam logic [7:0] RTCTL_DAY_MAX = 8'h06;
    localparam logic [7:0] RTCTL_MONTH_MAX = 8'h0c;
    localparam logic [7:0] RTCTL_YEAR_MAX = 8'h63;

    // ==========================================================
    // carriers: field k of the time sits at bits 8k+7..8k (address k)
    typedef struct packed {
        logic [7:0] day;
        logic [7:0] year;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] hund;
    } rtctl_time_t;

    localparam rtctl_time_t RTCTL_TIME_RST = '{8'h00, 8'h00, 8'h01, 8'h01,
                                              8'h00, 8'h00, 8'h00, 8'h00};

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [4:0] addr;
        logic [7:0] data;
    } rtctl_bus_t;

endpackage

// ===== hw/rtctl_sync.sv
// three-stage pin synchroniser, one lane per bit
// assumes the inputs are asynchronous to clock
module rtctl_sync #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // lanes
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // ==========================================================
    // shift chain
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ==========================================================
    // a lane changes only where stages two and three agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_out <= RST_VAL;
        end else begin
            sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg ^ s3_reg));
        end
    end
endmodule

// ===== verif/rtctl_cpu.sv
// processor model that drives the strobed register bus
// assumes the block's synced strobes answer within eight clocks
module rtctl_cpu
    import rtctl_pkg::*;
(
    // clock
    input wire logic clock,
    // bus towards the block
    output rtctl_bus_t bus,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus = RTCTL_BUS_RST;
    end

    // ==========================================================
    // one whole access; strobes held long enough for the 3-ff sync
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe_n);
        @(posedge clock);
        bus.cs_n <= 1'b0;
        bus.rd_n <= wr;
        bus.wr_n <= !wr;
        bus.addr <= a;
        bus.data <= d;
        repeat (8) @(posedge clock);
        q = data_out;
        oe_n = data_oe_n;
        bus.cs_n <= 1'b1;
        bus.rd_n <= 1'b1;
        bus.wr_n <= 1'b1;
        // released data lines show the inverse of the last value
        bus.data <= ~d;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ===== verif/rtctl_core_tb.sv
// self-checking bench for the clock latch and interrupt block
// assumes a shortened tick divider so the counters move quickly
module rtctl_core_tb;
    import rtctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned TDIV = 20;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    rtctl_bus_t bus;
    logic [7:0] data_out;
    logic data_oe_n, irq_out, irq_oe_n, irq_wire;
    int n_fail = 0;
    int checks_done = 0;

    always #10 clock = ~clock;
    // open-drain pin with pull-up
    assign irq_wire = irq_oe_n ? 1'b1 : irq_out;

    rtctl_cpu cpu (.clock(clock), .bus(bus), .data_out(data_out), .data_oe_n(data_oe_n));

    rtctl_core #(.TICK_DIV(TDIV)) dut (
        .clock(clock), .reset_n(reset_n), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .addr(bus.addr), .data_in(bus.data), .data_out(data_out), .data_oe_n(data_oe_n),
        .irq_in(irq_wire), .irq_out(irq_out), .irq_oe_n(irq_oe_n)
    );

    // ==========================================================
    // helpers
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic oe;
        cpu.access(1'b1, a, d, q, oe);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        logic oe;
        cpu.access(1'b0, a, 8'h00, q, oe);
        check("read_oe_n", {7'h00, oe}, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_latch();
        logic [7:0] q;
        rd(RTCTL_OFS_STATUS, q);
        check("status_rst", q, RTCTL_STATUS_RST);
        check("irq_rst", {7'h00, irq_oe_n}, 8'h01);
        wr(5'h01, 8'h05);
        rd(RTCTL_OFS_HUND, q);
        wr(5'h01, 8'h07);
        rd(5'h01, q);
        check("hour_latched", q, 8'h05);
        rd(5'h04, q);
        check("month_latched", q, 8'h01);
        rd(RTCTL_OFS_HUND, q);
        rd(5'h01, q);
        check("hour_fresh", q, 8'h07);
        wr(RTCTL_OFS_HUND, 8'h2a);
        rd(RTCTL_OFS_HUND, q);
        check("hund_live", q, 8'h2a);
        $display("test latch done");
    endtask

    task automatic t_alarm_store();
        logic [7:0] q;
        wr(5'h09, 8'h03);
        rd(5'h09, q);
        check("alarm_read", q, 8'h03);
        // every field masked, hundredths acts as zero
        for (int i = 8; i < 16; i++) begin
            wr(5'(i), 8'h80);
        end
        $display("test alarm store done");
    endtask

    task automatic irq_case(input logic [7:0] msk, input logic [7:0] cmd, input logic [7:0] want);
        logic [7:0] q;
        int n;
        wr(RTCTL_OFS_STATUS, 8'h00);
        rd(RTCTL_OFS_STATUS, q);
        wr(RTCTL_OFS_HUND, 8'h62);
        wr(RTCTL_OFS_STATUS, msk);
        wr(RTCTL_OFS_COMMAND, cmd);
        n = 0;
        while (n < 100 && irq_oe_n !== 1'b0) begin
            @(posedge clock);
            n++;
        end
        wr(RTCTL_OFS_COMMAND, 8'h00);
        check("irq_held", {7'h00, irq_oe_n}, {7'h00, ~want[7]});
        check("irq_pin", {7'h00, irq_wire}, {7'h00, ~want[7]});
        rd(RTCTL_OFS_STATUS, q);
        check("status_irq", q & 8'h81, want);
        check("status_cnt", q & 8'h0a, 8'h0a);
        check("irq_released", {7'h00, irq_oe_n}, 8'h01);
        rd(RTCTL_OFS_STATUS, q);
        check("status_clear", q, 8'h00);
        $display("test irq %h %h done", msk, cmd);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_latch();
        t_alarm_store();
        irq_case(8'h08, 8'h18, 8'h80);
        // test mode: a tick on every clock, hundredths periodic interrupt
        irq_case(8'h02, 8'h38, 8'h80);
        irq_case(8'h08, 8'h08, 8'h00);
        irq_case(8'h00, 8'h18, 8'h00);
        irq_case(8'h01, 8'h18, 8'h81);
        irq_case(8'h01, 8'h08, 8'h00);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        summarize();
    end
endmodule
